// File: bench/occ_tb.sv
// Self-checking bench for the oscillator control register
`include "occ_defines.svh"
module tb
  import occ_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B   = 32'h0000_5a81;
  localparam logic [31:0] HXE = 32'h1 << `OCC_BIT_HXEN;
  localparam logic [31:0] BPS = 32'h1 << `OCC_BIT_BPS;
  localparam logic [31:0] CKM = 32'h1 << `OCC_BIT_FAST_CRYSTAL_MONITOR_ENABLE;
  localparam logic [31:0] PLM = 32'h1 << `OCC_BIT_PLL_MONITOR_ENABLE;
  localparam logic [31:0] LCM = 32'h1 << `OCC_BIT_SLOW_CRYSTAL_MONITOR_ENABLE;
  localparam logic [11:0] CTL = `OCC_CTL_ADDR;
  localparam logic [11:0] STA = `OCC_STAT_ADDR;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lre = 0;
  logic        tick = 0, ledge = 0, hx_in = 0, hx_osc = 0, pready, pslverr, perr;
  logic        hx_out, fce, rc_run, force_rc, fail_ev, loss_rst, pll_fail, slow_fail;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [7:0]  trim = 8'h5a, rc_trim;
  occ_osc_s    osc = '0;
  occ_sys_s    sys = '0;
  int          failures = 0, tests_run = 0, n;
  always #10 clk = ~clk;
  occ_ctl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_async(osc), .sys_in(sys), .factory_trim(trim), .loss_reset_enable(lre),
    .tick_40k(tick), .slow_crystal_oscillator_edge(ledge), .hx_clk_in(hx_in), .hx_osc_out(hx_osc),
    .hx_clk_out(hx_out), .fast_crystal_enable(fce), .rc_run(rc_run), .rc_trim(rc_trim),
    .force_sys_rc(force_rc), .hx_fail_event(fail_ev), .hx_loss_reset(loss_rst),
    .pll_fail(pll_fail), .slow_fail(slow_fail));
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(CTL);
    chk(rdat, B);
    chk(rc_trim, 8'h6a);
    wr(CTL, 32'h0000_5af9);
    @(negedge clk);
    chk(rc_trim, 8'h79);
    wr(CTL, B);
  endtask
  task automatic t_flags;
    osc.hx_stable <= 1'b1;
    osc.rc_stable <= 1'b1;
    cyc(4);
    rd(CTL);
    chk(rdat, B | 32'h0002_0002);
    osc.hx_stable <= 1'b0;
    cyc(4);
    rd(CTL);
    chk(rdat, B | 32'h0000_0002);
  endtask
  task automatic t_bypass;
    wr(CTL, B | BPS);
    hx_in <= 1'b1;
    rd(CTL);
    chk(rdat & BPS, BPS);
    chk(hx_out, 1'b1);
    wr(CTL, B | BPS | HXE);
    wr(CTL, B | HXE);
    rd(CTL);
    chk(rdat & BPS, BPS);
    wr(CTL, B);
    wr(CTL, B);
    rd(CTL);
    chk(rdat & (BPS | HXE), 32'h0);
    chk(hx_out, hx_osc);
  endtask
  task automatic t_pll;
    wr(CTL, B | PLM);
    rd(CTL);
    chk(rdat & PLM, 32'h0);
    osc.pll_on <= 1'b1;
    cyc(4);
    wr(CTL, B | PLM | HXE);
    osc.pll_stuck <= 1'b1;
    sys.sys_is_hx <= 1'b1;
    wr(CTL, B | PLM);
    sys.sys_is_hx <= 1'b0;
    sys.pll_src_hx <= 1'b1;
    wr(CTL, B | PLM);
    sys.pll_src_hx <= 1'b0;
    rd(CTL);
    chk(rdat & (HXE | PLM), HXE | PLM);
    chk(pll_fail, 1'b1);
    osc.pll_unlock <= 1'b1;
    osc.pll_stuck <= 1'b0;
    cyc(4);
    rd(CTL);
    chk(rdat & PLM, 32'h0);
    osc.pll_unlock <= 1'b0;
    cyc(4);
    wr(CTL, B | PLM | HXE);
    sys.enter_lp <= 1'b1;
    cyc(1);
    sys.enter_lp <= 1'b0;
    rd(CTL);
    chk(rdat & (HXE | PLM), 32'h0);
  endtask
  task automatic t_rc;
    sys.sys_is_rc <= 1'b1;
    wr(CTL, B - 1);
    sys.sys_is_rc <= 1'b0;
    rd(CTL);
    chk(rdat[0], 1'b1);
    wr(CTL, B - 1);
    cyc(1);
    chk(rc_run, 1'b0);
    sys.leave_lp <= 1'b1;
    cyc(1);
    sys.leave_lp <= 1'b0;
    rd(CTL);
    chk(rdat[0], 1'b1);
  endtask
  task automatic t_ckm;
    wr(CTL, (B - 1) | CKM | HXE);
    cyc(1);
    chk(rc_run, 1'b1);
    osc.hx_stuck <= 1'b1;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (fail_ev === 1'b1)
        n++;
    end
    chk(n, 1);
    chk({force_rc, fce, loss_rst}, 3'b100);
    rd(CTL);
    chk(rdat & (HXE | 32'h1), 32'h1);
    rd(STA);
    chk(rdat[0], 1'b1);
    osc.hx_stuck <= 1'b0;
    cyc(4);
    wr(STA, 32'h0);
    @(negedge clk);
    chk(force_rc, 1'b1);
    wr(STA, 32'h1);
    cyc(1);
    chk(force_rc, 1'b0);
    lre <= 1'b1;
    osc.hx_stuck <= 1'b1;
    cyc(5);
    chk({force_rc, loss_rst}, 2'b01);
    osc.hx_stuck <= 1'b0;
  endtask
  task automatic t_slow;
    wr(CTL, B | LCM);
    osc.slow_crystal_oscillator_on <= 1'b1;
    cyc(4);
    wr(CTL, B | LCM);
    rd(CTL);
    chk(rdat & LCM, 32'h0);
    osc.internal_40khz_rc_oscillator_on <= 1'b1;
    cyc(4);
    wr(CTL, B | LCM);
    rd(CTL);
    chk(rdat & LCM, LCM);
    for (int i = 0; i < 40; i++)
    begin
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      @(negedge clk);
      if (i == 30)
        chk(slow_fail, 1'b0);
      @(posedge clk);
    end
    chk(slow_fail, 1'b1);
    ledge <= 1'b1;
    cyc(1);
    ledge <= 1'b0;
    cyc(4);
    chk(slow_fail, 1'b0);
  endtask
  task automatic t_bad;
    wr(12'h008, 32'hffff_ffff);
    chk(perr, 1'b1);
    chk(pready, 1'b1);
    rd(12'h008);
    chk({perr, rdat}, {1'b1, 32'h0});
    rd(CTL);
    chk({perr, rdat[21:16]}, {1'b0, 6'h20});
  endtask
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_bypass();
    t_pll();
    t_rc();
    t_ckm();
    t_slow();
    t_bad();
    wrap_up();
  end
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule

// File: core/occ_ctl.sv
// Oscillator control register with APB slave and hardware overrides
//
// Chosen here: the APB slave port and the register offsets.
`include "occ_defines.svh"
// What this block does
// RQ1: Detect slow crystal stuck or slowed
// RQ2: PLL monitor detects stuck PLL clock
// RQ3: PLL monitor set ignored when PLL off
// RQ4: Clear PLL monitor on low power, unlock
// RQ5: Stuck fast crystal switches system to RC
// RQ6: Failover ends by reset or flag clear
// RQ7: Crystal monitor keeps RC oscillator running
// RQ8: Bypass writable only when crystal disabled
// RQ9: Bypass passes input clock straight through
// RQ10: Crystal stable flag follows oscillator
// RQ11: Crystal enable uncleared while in use
// RQ12: Low power entry clears crystal enable
// RQ13: Factory calibration loaded at power on
// RQ14: Effective trim is adjust plus calibration
// RQ15: RC stable flag follows oscillator
// RQ16: RC enable uncleared while system clock
// RQ17: Hardware sets RC enable on events
// RQ18: Software keeps reserved bit two unchanged
// RQ19: Crystal failure sets flag, stops crystal
// RQ20: Slow monitor counter overflow means failure
// RQ21: Slow monitor set needs both clocks on
// RQ22: Oscillator status synchronised before use
module occ_ctl
  import occ_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire occ_osc_s    osc_async,
  input  wire occ_sys_s    sys_in,
  input  wire logic [7:0]  factory_trim,
  input  wire logic        loss_reset_enable,
  input  wire logic        tick_40k,
  input  wire logic        slow_crystal_oscillator_edge,
  input  wire logic        hx_clk_in,
  input  wire logic        hx_osc_out,
  output logic             hx_clk_out,
  output logic             fast_crystal_enable,
  output logic             rc_run,
  output logic [7:0]       rc_trim,
  output logic             force_sys_rc,
  output logic             hx_fail_event,
  output logic             hx_loss_reset,
  output logic             pll_fail,
  output logic             slow_fail
);
  // ------------------------------------------------------------
  // Status synchroniser
  // ------------------------------------------------------------
  occ_osc_s sync1_reg;
  occ_osc_s osc;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      osc       <= '0;
    end
    else
    begin
      sync1_reg <= osc_async; // [RQ22]
      osc       <= sync1_reg;
    end
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic       rcen_reg;
  logic       hxen_reg;
  logic       bps_reg;
  logic       fast_crystal_monitor_enable_reg;
  logic       pll_monitor_enable_reg;
  logic       slow_crystal_monitor_enable_reg;
  logic       rsvd_reg;
  logic [4:0] adj_reg;
  logic [7:0] cal_reg;
  logic       cal_loaded_reg;
  logic       stuck_reg;
  logic       fail_d_reg;

  wire wr_en   = psel && penable && pwrite;
  wire hit_ctl = (paddr == `OCC_CTL_ADDR);
  wire hit_st  = (paddr == `OCC_STAT_ADDR);
  wire wr_ctl  = wr_en && hit_ctl;
  wire wr_st   = wr_en && hit_st;

  wire hx_fail    = fast_crystal_monitor_enable_reg && osc.hx_stuck;
  wire hx_fail_nr = hx_fail && !loss_reset_enable;
  wire hx_in_use  = sys_in.sys_is_hx || sys_in.pll_src_hx;

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  wire w_rcen   = pwdata[`OCC_BIT_RCEN];
  wire w_hxen   = pwdata[`OCC_BIT_HXEN];
  wire w_pll_monitor_enable = pwdata[`OCC_BIT_PLL_MONITOR_ENABLE];
  wire w_slow_crystal_monitor_enable = pwdata[`OCC_BIT_SLOW_CRYSTAL_MONITOR_ENABLE];

  wire rcen_sw  = wr_ctl ? (w_rcen || sys_in.sys_is_rc || force_sys_rc) : rcen_reg; // [RQ16]
  wire rcen_next = rcen_sw || sys_in.leave_lp || hx_fail; // [RQ17]

  wire hxen_sw  = wr_ctl ? (w_hxen || hx_in_use) : hxen_reg; // [RQ11]
  wire hxen_next = hxen_sw && !sys_in.enter_lp && !hx_fail_nr; // [RQ12] [RQ19]

  wire bps_next = (wr_ctl && !hxen_reg) ? pwdata[`OCC_BIT_BPS] : bps_reg; // [RQ8]

  wire pll_monitor_enable_sw = wr_ctl ? (w_pll_monitor_enable && (osc.pll_on || pll_monitor_enable_reg)) : pll_monitor_enable_reg; // [RQ3]
  wire pll_monitor_enable_next = pll_monitor_enable_sw && !sys_in.enter_lp && !osc.pll_unlock; // [RQ4]

  wire lck_ok = osc.slow_crystal_oscillator_on && osc.internal_40khz_rc_oscillator_on;
  wire slow_crystal_monitor_enable_next = wr_ctl ? (w_slow_crystal_monitor_enable && (lck_ok || slow_crystal_monitor_enable_reg)) : slow_crystal_monitor_enable_reg; // [RQ21]

  // Failover flag: set wins over software clear
  wire stuck_next = hx_fail_nr || (stuck_reg && !(wr_st && pwdata[0])); // [RQ6]

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rcen_reg   <= 1'b1;
      hxen_reg   <= 1'b0;
      bps_reg    <= 1'b0;
      fast_crystal_monitor_enable_reg  <= 1'b0;
      pll_monitor_enable_reg <= 1'b0;
      slow_crystal_monitor_enable_reg <= 1'b0;
      rsvd_reg   <= 1'b0;
      adj_reg    <= `OCC_ADJ_RESET;
      stuck_reg  <= 1'b0;
      fail_d_reg <= 1'b0;
    end
    else
    begin
      rcen_reg   <= rcen_next;
      hxen_reg   <= hxen_next;
      bps_reg    <= bps_next;
      fast_crystal_monitor_enable_reg  <= wr_ctl ? pwdata[`OCC_BIT_FAST_CRYSTAL_MONITOR_ENABLE] : fast_crystal_monitor_enable_reg;
      pll_monitor_enable_reg <= pll_monitor_enable_next;
      slow_crystal_monitor_enable_reg <= slow_crystal_monitor_enable_next;
      rsvd_reg   <= wr_ctl ? pwdata[`OCC_BIT_RSVD2] : rsvd_reg; // [RQ18]
      adj_reg    <= wr_ctl ? pwdata[`OCC_BIT_ADJ_LO +: 5] : adj_reg;
      stuck_reg  <= stuck_next;
      fail_d_reg <= hx_fail;
    end
  end

  // Calibration captured at the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cal_loaded_reg <= 1'b0;
    else
      cal_loaded_reg <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!cal_loaded_reg) cal_reg <= factory_trim; // [RQ13]
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rc_trim             = cal_reg + {3'h0, adj_reg}; // [RQ14]
  assign rc_run              = rcen_reg || fast_crystal_monitor_enable_reg; // [RQ7]
  assign hx_clk_out          = bps_reg ? hx_clk_in : hx_osc_out; // [RQ9]
  assign fast_crystal_enable = hxen_reg;
  assign force_sys_rc        = stuck_reg; // [RQ5]
  assign hx_fail_event       = hx_fail_nr && !fail_d_reg; // [RQ19]
  assign hx_loss_reset       = hx_fail && loss_reset_enable;
  assign pll_fail            = pll_monitor_enable_reg && osc.pll_stuck; // [RQ2]

  occ_slow_mon u_slow_mon
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (slow_crystal_monitor_enable_reg),
    .tick_40k   (tick_40k),
    .slow_crystal_oscillator_edge (slow_crystal_oscillator_edge),
    .fail       (slow_fail)
  );

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  wire [31:0] ctl_word = {10'h000, slow_crystal_monitor_enable_reg, pll_monitor_enable_reg, fast_crystal_monitor_enable_reg, bps_reg,
                          osc.hx_stable, hxen_reg, cal_reg, adj_reg, rsvd_reg,
                          osc.rc_stable, rcen_reg}; // [RQ10] [RQ15]
  wire [31:0] st_word  = {31'h00000000, stuck_reg};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_ctl && !hit_st;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= hit_ctl ? ctl_word : (hit_st ? st_word : 32'h00000000);
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_pll_monitor_enable_off_pll: assert property (@(posedge clk) disable iff (!rst_n)
    (!pll_monitor_enable_reg && !osc.pll_on) |=> !pll_monitor_enable_reg) else $error("pll monitor set with pll off"); // [RQ3]
  a_pll_monitor_enable_lp_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_in.enter_lp || osc.pll_unlock) |=> !pll_monitor_enable_reg) else $error("pll monitor kept"); // [RQ4]
  a_hxen_lp_clr: assert property (@(posedge clk) disable iff (!rst_n)
    sys_in.enter_lp |=> !hxen_reg) else $error("crystal enable kept in low power"); // [RQ12]
  a_bps_locked: assert property (@(posedge clk) disable iff (!rst_n)
    hxen_reg |=> $stable(bps_reg)) else $error("bypass changed while enabled"); // [RQ8]
  a_rcen_held: assert property (@(posedge clk) disable iff (!rst_n)
    (rcen_reg && sys_in.sys_is_rc) |=> rcen_reg) else $error("rc enable cleared"); // [RQ16]
  a_rc_set_hw: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_in.leave_lp || hx_fail) |=> rcen_reg) else $error("rc enable not set"); // [RQ17]
  a_fail_stops_hx: assert property (@(posedge clk) disable iff (!rst_n)
    hx_fail_nr |=> (stuck_reg && !hxen_reg && force_sys_rc)) else $error("failover missing"); // [RQ19]
  a_hxen_in_use: assert property (@(posedge clk) disable iff (!rst_n)
    (hxen_reg && hx_in_use && !sys_in.enter_lp && !hx_fail_nr) |=> hxen_reg)
    else $error("crystal enable cleared in use"); // [RQ11]
  a_stuck_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (stuck_reg && !wr_st) |=> stuck_reg) else $error("failover ended early"); // [RQ6]
  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
    ##2 osc.hx_stable == $past(osc_async.hx_stable, 2)) else $error("sync depth wrong"); // [RQ22]

  // ------------------------------------------------------------
  // Checks: outputs, flags and gated writes
  // ------------------------------------------------------------
  a_pll_fail_seen: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    (pll_monitor_enable_reg && osc.pll_stuck) |-> pll_fail)
    else $error("pll stuck not reported");
  a_pll_fail_gated: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    !pll_monitor_enable_reg |-> !pll_fail)
    else $error("pll fail without monitor");
  a_pll_monitor_enable_set: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
    (wr_ctl && w_pll_monitor_enable && osc.pll_on && !sys_in.enter_lp && !osc.pll_unlock) |=> pll_monitor_enable_reg)
    else $error("pll monitor set lost");
  a_failover_cause: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
    $rose(force_sys_rc) |-> $past(hx_fail_nr))
    else $error("failover without crystal failure");
  a_stuck_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6]
    (wr_st && pwdata[0] && !hx_fail_nr) |=> !stuck_reg)
    else $error("stuck flag not cleared");
  a_rc_kept_on: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
    fast_crystal_monitor_enable_reg |-> rc_run)
    else $error("rc stopped under crystal monitor");
  a_bps_write: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
    (wr_ctl && !hxen_reg && pwdata[`OCC_BIT_BPS]) |=> bps_reg)
    else $error("bypass write lost");
  a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
    bps_reg |-> (hx_clk_out == hx_clk_in))
    else $error("bypass path wrong");
  a_osc_path: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
    !bps_reg |-> (hx_clk_out == hx_osc_out))
    else $error("oscillator path wrong");
  a_hx_flag_sync: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
    ##2 (ctl_word[`OCC_BIT_HXSTB] == $past(osc_async.hx_stable, 2)))
    else $error("crystal stable flag wrong");
  a_cal_frozen: assert property (@(posedge clk) disable iff (!rst_n) // [RQ13]
    cal_loaded_reg |=> $stable(cal_reg))
    else $error("calibration changed after load");
  a_trim_follows: assert property (@(posedge clk) disable iff (!rst_n) // [RQ14]
    ($changed(adj_reg) && $stable(cal_reg)) |-> $changed(rc_trim))
    else $error("trim ignores adjust");
  a_rc_flag_sync: assert property (@(posedge clk) disable iff (!rst_n) // [RQ15]
    ##2 (ctl_word[`OCC_BIT_RCSTB] == $past(osc_async.rc_stable, 2)))
    else $error("rc stable flag wrong");
  a_rc_forced_held: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
    (rcen_reg && force_sys_rc) |=> rcen_reg)
    else $error("rc enable cleared during failover");
  a_event_once: assert property (@(posedge clk) disable iff (!rst_n) // [RQ19]
    hx_fail_event |=> !hx_fail_event)
    else $error("failure event longer than one cycle");
  a_event_cause: assert property (@(posedge clk) disable iff (!rst_n) // [RQ19]
    hx_fail_event |-> (fast_crystal_monitor_enable_reg && !loss_reset_enable))
    else $error("failure event without cause");
  a_slow_needs_en: assert property (@(posedge clk) disable iff (!rst_n) // [RQ1]
    slow_fail |-> $past(slow_crystal_monitor_enable_reg))
    else $error("slow failure without monitor");
  a_slow_crystal_monitor_enable_gate: assert property (@(posedge clk) disable iff (!rst_n) // [RQ21]
    (!slow_crystal_monitor_enable_reg && !(osc.slow_crystal_oscillator_on && osc.internal_40khz_rc_oscillator_on)) |=> !slow_crystal_monitor_enable_reg)
    else $error("slow monitor set with clocks off");
  a_osc_sync_all: assert property (@(posedge clk) disable iff (!rst_n) // [RQ22]
    ##2 (osc == $past(osc_async, 2)))
    else $error("status sync depth wrong");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  c_failover: cover property (@(posedge clk) disable iff (!rst_n) hx_fail_nr ##1 stuck_reg);
  c_flag_clear: cover property (@(posedge clk) disable iff (!rst_n) stuck_reg ##1 !stuck_reg);
  c_slow_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(slow_fail));
  c_bypass_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(bps_reg));
  c_loss_reset: cover property (@(posedge clk) disable iff (!rst_n) $rose(hx_loss_reset));
endmodule

// File: core/occ_defines.svh
// Offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH
`define OCC_CTL_ADDR      12'h000
`define OCC_STAT_ADDR     12'h004
`define OCC_BIT_RCEN      0
`define OCC_BIT_RCSTB     1
`define OCC_BIT_RSVD2     2
`define OCC_BIT_ADJ_LO    3
`define OCC_BIT_CAL_LO    8
`define OCC_BIT_HXEN      16
`define OCC_BIT_HXSTB     17
`define OCC_BIT_BPS       18
`define OCC_BIT_FAST_CRYSTAL_MONITOR_ENABLE     19
`define OCC_BIT_PLL_MONITOR_ENABLE    20
`define OCC_BIT_SLOW_CRYSTAL_MONITOR_ENABLE    21
`define OCC_ADJ_RESET     5'h10
`define OCC_LCNT_MAX      5'h1f
`endif

// File: core/occ_pkg.sv
// Types shared by the oscillator control block
package occ_pkg;
  typedef struct packed {
    logic       hx_stable;
    logic       rc_stable;
    logic       pll_on;
    logic       pll_unlock;
    logic       hx_stuck;
    logic       pll_stuck;
    logic       slow_crystal_oscillator_on;
    logic       internal_40khz_rc_oscillator_on;
  } occ_osc_s;
  typedef struct packed {
    logic       sys_is_hx;
    logic       sys_is_rc;
    logic       pll_src_hx;
    logic       enter_lp;
    logic       leave_lp;
  } occ_sys_s;
endpackage

// File: core/occ_slow_mon.sv
// Slow crystal monitor: counter on 40 kHz enable, cleared by slow crystal edges
`include "occ_defines.svh"
module occ_slow_mon
  import occ_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic tick_40k,
  input  wire logic slow_crystal_oscillator_edge,
  output logic      fail
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  wire        at_max = (cnt_reg == `OCC_LCNT_MAX);
  // 5-bit counter saturating at 31; slow or stuck crystal lets it overflow [RQ20] [RQ1]
  assign cnt_next = (!enable || slow_crystal_oscillator_edge) ? 5'h00 :
                    (tick_40k && !at_max) ? cnt_reg + 5'h01 : cnt_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n) cnt_reg <= 5'h00;
    else        cnt_reg <= cnt_next;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n) fail <= 1'b0;
    else        fail <= enable && at_max;
  end
  a_overflow_fail: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && at_max && !slow_crystal_oscillator_edge) |=> fail) else $error("overflow not flagged"); // [RQ20]
endmodule
